// [rtl/apr_pkg.sv]
// Purpose: shared constants and types for the converter host port controller
// Assumes: 200 MHz system clock
// Notes:   times are kept in ns and turned into cycle counts here
package apr_pkg;
  localparam int unsigned CLK_NS       = 5;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CHAN_W       = 3;
  // host-side timing, converter port
  localparam int unsigned ACQ_NS       = 30;    // read end to next start, high-speed mode
  localparam int unsigned PWRUP_NS     = 1000;  // power-up with external reference
  localparam int unsigned STROBE_NS    = 20;    // least low time of start and read strobes
  localparam int unsigned EOC_MAX_NS   = 110;   // longest end-of-conversion pulse
  localparam int unsigned ACQ_CYC      = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PWRUP_CYC    = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EOC_MAX_CYC  = EOC_MAX_NS / CLK_NS;
  localparam int unsigned TMR_W        = 16;

  // one user command
  typedef struct packed {
    logic [CHAN_W-1:0] chan;   // channel for the following conversion
    logic              low_power; // power down after this conversion
  } apr_cmd_s;

  // one returned sample
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] data;
  } apr_res_s;
endpackage : apr_pkg

// [rtl/apr_host.sv]
// Purpose: host controller driving a parallel 8-bit sampling converter port
// Assumes: converter pins are asynchronous to CLK_I and synchronised here
// Notes:   one conversion per command; result returned with its channel
//
// What this block does
// - end pulse used as edge interrupt
// - data valid while select and read low
// - select driven low only together with read, never alone
// - end pulse may drive select and read
// - channel from the three chan bits of the command
// - select decode ignores channel bits
// - start strobe alone runs stand-alone mode
// - wait 30 ns after read before start
`timescale 1ns/1ps
module apr_host #(
  parameter int unsigned NUM_CHAN  = 8,
  parameter int unsigned PWRUP_CYC = apr_pkg::PWRUP_CYC
) (
  input  wire logic                       CLK_I,
  input  wire logic                       SYS_RST_I,
  input  wire logic                       CMD_VALID_I,
  output logic                            CMD_READY_O,
  input  wire apr_pkg::apr_cmd_s          CMD_I,
  output logic                            RES_VALID_O,
  output apr_pkg::apr_res_s               RES_O,
  output logic                            CONVERT_START_N_O,
  output logic                            CS_N_O,
  output logic                            RD_N_O,
  output logic [apr_pkg::CHAN_W-1:0]      CHANNEL_SEL_O,
  input  wire logic                       EOC_N_I,
  input  wire logic [apr_pkg::DATA_W-1:0] DB_I,
  output logic                            TIMEOUT_O
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAKE, ST_START, ST_WAIT_EOC, ST_READ, ST_HOLD, ST_ACQ
  } apr_state_e;

  apr_state_e                 state;
  logic [apr_pkg::TMR_W-1:0]  tmr;
  logic                       eoc_q1;
  logic                       eoc_q2;
  logic                       eoc_q3;
  logic [apr_pkg::DATA_W-1:0] db_q1;
  logic [apr_pkg::DATA_W-1:0] db_q2;
  logic                       powered;
  apr_pkg::apr_cmd_s          cmd;
  logic                       eoc_fall;
  // tmr times every timed state and is cleared on each move
  logic                       woken;     // start has risen since reset
  logic [apr_pkg::CHAN_W-1:0] read_chan; // channel the part latched last

  // two-flop synchronisers; third stage only for edge detect
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      eoc_q1 <= 1'b1;
      eoc_q2 <= 1'b1;
      eoc_q3 <= 1'b1;
      db_q1  <= '0;
      db_q2  <= '0;
    end else begin
      eoc_q1 <= EOC_N_I;
      eoc_q2 <= eoc_q1;
      eoc_q3 <= eoc_q2;
      db_q1  <= DB_I;
      db_q2  <= db_q1;
    end
  end

  // end pulse treated as a falling-edge event, not a level
  assign eoc_fall    = eoc_q3 & ~eoc_q2;
  // ready straight from state, so a command is taken in the cycle it is seen
  assign CMD_READY_O = (state == ST_IDLE);

  // conversion sequencer
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state   <= ST_IDLE;
      tmr     <= '0;
      cmd     <= '0;
      powered <= 1'b0;
      woken   <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (CMD_VALID_I) begin
            cmd   <= CMD_I;
            tmr   <= '0;
            // part starts unpowered; wake it with a rising start edge first
            state <= powered ? ST_START : ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (!woken) begin
            // nothing has risen since reset: pulse start low so its rise wakes the part
            if (tmr == apr_pkg::TMR_W'(apr_pkg::STROBE_CYC - 1)) begin
              tmr   <= '0;
              woken <= 1'b1;
            end else begin
              tmr <= tmr + 1'b1;
            end
          end else if (tmr == apr_pkg::TMR_W'(PWRUP_CYC - 1)) begin
            // start stays high for PWRUP_CYC cycles; the part can still see the fall just before its power-up ends and hold it pending
            tmr     <= '0;
            powered <= 1'b1;
            state   <= ST_START;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        ST_START: begin
          // start held low for the strobe time, conversion begins at the fall
          if (tmr == apr_pkg::TMR_W'(apr_pkg::STROBE_CYC - 1)) begin
            tmr   <= '0;
            state <= ST_WAIT_EOC;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        ST_WAIT_EOC: begin
          if (eoc_fall) begin
            tmr   <= '0;
            state <= ST_READ;
          end else if (tmr == apr_pkg::TMR_W'(PWRUP_CYC - 1)) begin
            tmr   <= '0;
            state <= ST_HOLD;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        ST_READ: begin
          // read held long enough for bus settle plus synchroniser delay
          if (tmr == apr_pkg::TMR_W'(apr_pkg::STROBE_CYC + 1)) begin
            tmr   <= '0;
            state <= ST_HOLD;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        ST_HOLD: begin
          // in low-power mode keep start low past the end pulse so the part samples the mode; high-speed mode moves on at once
          // the rise on the move to ACQ begins the next wake, so woken stays set
          if (!cmd.low_power || tmr == apr_pkg::TMR_W'(apr_pkg::EOC_MAX_CYC)) begin
            tmr     <= '0;
            powered <= ~cmd.low_power;
            state   <= ST_ACQ;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        ST_ACQ: begin
          if (tmr == apr_pkg::TMR_W'(apr_pkg::ACQ_CYC - 1)) begin
            tmr   <= '0;
            state <= ST_IDLE;
          end else begin
            tmr <= tmr + 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // pin drive from flops; in low-power mode start low from conversion to mode sampling
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      CONVERT_START_N_O <= 1'b1;
      CS_N_O            <= 1'b1;
      RD_N_O            <= 1'b1;
      CHANNEL_SEL_O     <= '0;
    end else begin
      // high-speed mode lifts start after the strobe so the end rise samples it high;
      // low-power mode holds it low until the part has sampled the level
      CONVERT_START_N_O <= ~((state == ST_START) || (state == ST_WAKE && !woken) ||
                             (cmd.low_power && (state == ST_WAIT_EOC || state == ST_READ ||
                                                state == ST_HOLD)));
      CS_N_O            <= ~(state == ST_READ);
      RD_N_O            <= ~(state == ST_READ);
      // channel set up from the command ahead of the read so the falling edge latches it
      if (NUM_CHAN > 1) begin
        CHANNEL_SEL_O <= cmd.chan;
      end else begin
        CHANNEL_SEL_O <= '0;
      end
    end
  end

  // capture the byte at the end of the read window
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      RES_VALID_O <= 1'b0;
      RES_O       <= '0;
      TIMEOUT_O   <= 1'b0;
      read_chan   <= '0;
    end else begin
      RES_VALID_O <= 1'b0;
      TIMEOUT_O   <= 1'b0;
      if (state == ST_READ && tmr == apr_pkg::TMR_W'(apr_pkg::STROBE_CYC + 1)) begin
        RES_VALID_O <= 1'b1;
        RES_O.data  <= db_q2;
        // byte belongs to the channel the part latched at the previous read
        RES_O.chan  <= read_chan;
        read_chan   <= CHANNEL_SEL_O;
      end
      // no end pulse within the wait budget: report and move on
      if (state == ST_WAIT_EOC && !eoc_fall && tmr == apr_pkg::TMR_W'(PWRUP_CYC - 1)) begin
        TIMEOUT_O <= 1'b1;
      end
    end
  end
endmodule // apr_host

// [dv/apr_host_chk.sv]
// Purpose: port checks for the converter host controller
// Assumes: one clock, sync active-high reset
// Notes:   bound onto every apr_host instance
`timescale 1ns/1ps
module apr_host_chk (
  input wire logic       CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic       CMD_VALID_I,
  input wire logic       CMD_READY_O,
  input wire logic       RES_VALID_O,
  input wire logic       CONVERT_START_N_O,
  input wire logic       CS_N_O,
  input wire logic       RD_N_O,
  input wire logic [2:0] CHANNEL_SEL_O,
  input wire logic       EOC_N_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // strobe shapes and spacing on the converter pins
  chk_read_pair: assert property (RD_N_O == CS_N_O) else $error("select and read split");
  chk_read_low: assert property ($fell(RD_N_O) |-> !RD_N_O [*4]) else $error("read too short");
  chk_start_low: assert property ($fell(CONVERT_START_N_O) |-> !CONVERT_START_N_O [*4])
    else $error("start too short");
  chk_acq_gap: assert property ($rose(RD_N_O) |=> !$fell(CONVERT_START_N_O) [*6])
    else $error("start too soon after read");
  chk_chan_hold: assert property (!RD_N_O && !$past(RD_N_O) |-> $stable(CHANNEL_SEL_O))
    else $error("channel moved in read");
  chk_read_on_eoc: assert property ($fell(RD_N_O) |-> !EOC_N_I) else $error("read without end pulse");
  // result hand-off follows the read
  chk_res_read: assert property (RES_VALID_O |-> !$past(RD_N_O) || !$past(RD_N_O, 2))
    else $error("result without read");
  chk_res_pulse: assert property (RES_VALID_O |=> !RES_VALID_O) else $error("result not a pulse");
  chk_take_cmd: assert property (CMD_VALID_I && CMD_READY_O |=> !CMD_READY_O) else $error("ready stayed");
endmodule // apr_host_chk
bind apr_host apr_host_chk u_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CMD_VALID_I(CMD_VALID_I),
  .CMD_READY_O(CMD_READY_O), .RES_VALID_O(RES_VALID_O), .CONVERT_START_N_O(CONVERT_START_N_O),
  .CS_N_O(CS_N_O), .RD_N_O(RD_N_O), .CHANNEL_SEL_O(CHANNEL_SEL_O), .EOC_N_I(EOC_N_I));

// [dv/apr_conv_model.sv]
// Purpose: behavioural 8-bit sampling converter on the parallel port
// Assumes: pins sampled on the bench clock, external reference
// Notes:   result is 8'h50 plus the converted channel
`timescale 1ns/1ps
module apr_conv_model #(parameter int PWR = 200, parameter int CONV = 20, parameter int EOCW = 22,
                        parameter int NCH = 8) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic [2:0] chan_i,
  output logic            eoc_n_o,
  output logic [7:0]      db_o
);
  logic       pwr, pend, ps, pr;
  logic [2:0] lat, conv;
  logic [7:0] res;
  int         wcnt, ccnt, ecnt;
  // released port shows the inverse, so a stale byte never matches
  assign db_o = (!cs_n_i && !rd_n_i) ? res : ~res;
  // power, conversion and end pulse; counters step before they reload
  always @(posedge clk_i) begin
    ps <= start_n_i;
    pr <= rd_n_i;
    if (rst_i) begin
      pwr <= 1'b0;
      pend <= 1'b0;
      lat <= 3'h0;
      res <= 8'h00;
      wcnt <= 0;
      ccnt <= 0;
      ecnt <= 0;
      eoc_n_o <= 1'b1;
    end else begin
      if (wcnt > 0) wcnt <= wcnt - 1;
      if (ccnt > 0) ccnt <= ccnt - 1;
      if (ecnt > 0) ecnt <= ecnt - 1;
      if (wcnt == 1) pwr <= 1'b1;
      if (start_n_i && !ps && !pwr && wcnt == 0) wcnt <= PWR;
      // a fall while the part is unpowered and no wake is under way is ignored
      if (!start_n_i && ps && (pwr || wcnt > 0)) pend <= 1'b1;
      if (pend && pwr && ccnt == 0 && eoc_n_o) begin
        pend <= 1'b0;
        ccnt <= CONV;
        conv <= lat;
      end
      if (ccnt == 1) begin
        res <= 8'h50 + 8'(conv);
        eoc_n_o <= 1'b0;
        ecnt <= EOCW;
      end
      if (!eoc_n_o && (ecnt == 1 || (rd_n_i && !pr))) begin
        eoc_n_o <= 1'b1;
        if (!start_n_i) pwr <= 1'b0;
      end
      if (!rd_n_i && pr && NCH > 1) lat <= chan_i;
    end
  end
endmodule // apr_conv_model

// [dv/apr_host_tb.sv]
// Purpose: self-checking bench for the converter host controller
// Assumes: model converter answers on the far side
// Notes:   byte expected is 8'h50 plus channel latched at the previous read
`timescale 1ns/1ps
module apr_host_tb;
  logic              clk = 1'b0, rst = 1'b1, vld = 1'b0;
  apr_pkg::apr_cmd_s cmd = '0;
  apr_pkg::apr_res_s res;
  logic              rdy, res_vld, cst_n, cs_n, rd_n, eoc_n, tmo;
  logic [2:0]        chan, prev = 3'h0;
  logic [7:0]        db;
  apr_pkg::apr_res_s s_res;
  logic              s_vld, s_cst_n, s_cs_n, s_rd_n, s_eoc_n, s_tmo;
  logic [2:0]        s_chan;
  logic [7:0]        s_db;
  int                n_fail = 0, checks = 0, n_to = 0;
  apr_host dut (.CLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(vld), .CMD_READY_O(rdy), .CMD_I(cmd),
    .RES_VALID_O(res_vld), .RES_O(res), .CONVERT_START_N_O(cst_n), .CS_N_O(cs_n), .RD_N_O(rd_n),
    .CHANNEL_SEL_O(chan), .EOC_N_I(eoc_n), .DB_I(db), .TIMEOUT_O(tmo));
  apr_conv_model u_conv (.clk_i(clk), .rst_i(rst), .start_n_i(cst_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .chan_i(chan), .eoc_n_o(eoc_n), .db_o(db));
  // single-channel build in lock step with dut; its channel pins must stay at zero
  apr_host #(.NUM_CHAN(1)) dut_single (.CLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(vld), .CMD_READY_O(),
    .CMD_I(cmd), .RES_VALID_O(s_vld), .RES_O(s_res), .CONVERT_START_N_O(s_cst_n), .CS_N_O(s_cs_n),
    .RD_N_O(s_rd_n), .CHANNEL_SEL_O(s_chan), .EOC_N_I(s_eoc_n), .DB_I(s_db), .TIMEOUT_O(s_tmo));
  apr_conv_model #(.NCH(1)) u_conv_single (.clk_i(clk), .rst_i(rst), .start_n_i(s_cst_n), .cs_n_i(s_cs_n),
    .rd_n_i(s_rd_n), .chan_i(s_chan), .eoc_n_o(s_eoc_n), .db_o(s_db));
  initial forever #2.5 clk = ~clk;
  // a timeout pulse means the end pulse was missed
  always @(posedge clk) if (tmo === 1'b1 || s_tmo === 1'b1) n_to++;
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one command, held until taken, then its result judged
  task automatic run(input logic [2:0] ch, input logic lp);
    int n;
    cmd <= {ch, lp};
    vld <= 1'b1;
    for (n = 0; n < 400 && rdy !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    vld <= 1'b0;
    for (n = 0; n < 600 && res_vld !== 1'b1; n++) @(negedge clk);
    cmp8({7'h00, res_vld}, 8'h01);
    cmp8(res.data, 8'h50 + 8'(prev));
    cmp8({5'h00, res.chan}, {5'h00, prev});
    cmp8({7'h00, s_vld}, 8'h01);
    cmp8(s_res.data, 8'h50);
    cmp8({2'h0, s_res.chan, s_chan}, 8'h00);
    prev = ch;
  endtask
  task automatic t_wake();
    run(3'h5, 1'b0);
  endtask
  task automatic t_hop();
    for (int c = 0; c < 8; c++) run(3'(c), 1'b0);
  endtask
  task automatic t_lowpwr();
    run(3'h2, 1'b1);
    run(3'h6, 1'b0);
    cmp8(8'(n_to), 8'h00);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    results();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_wake();
    t_hop();
    t_lowpwr();
    results();
  end
endmodule // apr_host_tb
